// ===== include/vrss_pkg.sv
/*
 * Package of the status block: opcodes, field positions, counts.
 * Assumes it is compiled before every design file that imports it.
 */
package vrss_pkg;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int PSW_WIDTH       = 16;
    localparam int SSB_WIDTH       = 8;
    localparam int ROW_WIDTH       = 11;
    localparam int PSW_ERR_BIT     = 0;
    localparam int PSW_FULL_BIT    = 1;
    localparam int PSW_PWR_BIT     = 2;
    localparam int PSW_EOM_BIT     = 3;
    localparam int PSW_DONE_BIT    = 4;
    localparam int PSW_ROW_LO_POS  = 5;   // row bits 2..0 sit at 7..5
    localparam int PSW_ROW_HI_POS  = 8;   // row bits 10..3 sit at 15..8
    localparam int SSB_RDY_BIT     = 0;
    localparam int SSB_ERASE_BIT   = 1;
    localparam int SSB_PLAY_BIT    = 2;
    localparam int SSB_REC_BIT     = 3;
    localparam int SSB_EFFECT_POS  = 4;
    localparam int EFFECT_SLOTS    = 4;

    // ------------------------------------------------------------
    // command set
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_LED_MASK  = 8'hef;  // bit 4 drives the led only
    localparam logic [7:0] CMD_POWER_UP  = 8'h01;
    localparam logic [7:0] CMD_STOP      = 8'h02;
    localparam logic [7:0] CMD_RESET     = 8'h03;
    localparam logic [7:0] CMD_CLEAR     = 8'h04;
    localparam logic [7:0] CMD_STATUS    = 8'h05;
    localparam logic [7:0] CMD_POWER_DN  = 8'h07;
    localparam logic [7:0] CMD_DEVID     = 8'h09;
    localparam logic [7:0] CMD_SET_PLAY  = 8'h80;
    localparam logic [7:0] CMD_SET_REC   = 8'h81;
    localparam logic [7:0] CMD_SET_ERASE = 8'h82;
    localparam int         ADDR_BYTES    = 5;

    // ------------------------------------------------------------
    // fault indication and frame counters
    // ------------------------------------------------------------
    localparam int          FAULT_FLASHES   = 7;
    localparam int          FLASH_HALF_DFLT = 25000000;
    localparam logic [4:0]  LINK_POS_WRAP   = 5'h10;
    localparam logic [3:0]  LINK_BYTES_MAX  = 4'hf;

endpackage

// ===== hdl/vrss_sync.sv
/*
 * Three-stage synchroniser for a level from another clock domain.
 * Assumes din is quasi-static for several clk periods.
 */
`timescale 1ns/1ps
module vrss_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ------------------------------------------------------------
    // stages; output moves once stage two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            dout   <= RESET_VAL;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end

endmodule

// ===== hdl/vrss_status_regs.sv
/*
 * Status reporting of the recorder over its serial host port: builds the
 * primary status word and secondary status byte, shifts them out, screens
 * commands, and flashes the indicator on a memory layout fault.
 * Assumes sclk idles high, ss_n falls at least 16 ns before the first sclk
 * edge, and frames are separated by at least 40 ns of ss_n high.
 */
`timescale 1ns/1ps

// Overview of operation
// [R01] host arranges messages in circular layout first
// [R02] host leaves at most one empty slot
// [R03] host resets device around leaving serial mode
// [R04] layout fault flashes indicator seven times
// [R05] primary word: five flags, eleven row bits
// [R06] row bits 2..0 at 7..5, rest high
// [R07] row field shows the active memory row
// [R08] done flag sticky until clear command
// [R09] end-of-message flag sticky until clear command
// [R10] powered flag high while in serial mode
// [R11] full flag mirrors memory full
// [R12] invalid command sets error, not executed; code flags only short address commands and busy rejects
// [R13] every frame starts with primary word, low first
// [R14] status read returns secondary byte third
// [R15] secondary byte: effects, rec, play, erase, ready
// [R16] effect flags set on record, cleared on erase
// [R17] activity bits high during their operation
// [R18] busy device rejects non-priority commands; code also rejects power-up, device id, and stop during erase
// [R19] effect bit order selectable, default slot four high
module vrss_status_regs
    import vrss_pkg::*;
#(
    parameter int FLASH_HALF    = vrss_pkg::FLASH_HALF_DFLT,
    parameter bit EFFECT_ONE_HI = 1'b0
) (
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    input  wire logic                            sclk,
    input  wire logic                            ss_n,
    input  wire logic                            mosi,
    output logic                                 miso_out,
    output logic                                 miso_oe,
    input  wire logic [vrss_pkg::ROW_WIDTH-1:0]  active_row_address,
    input  wire logic                            op_done,
    input  wire logic                            eom_detect,
    input  wire logic                            powered_in,
    input  wire logic                            spi_mode,
    input  wire logic                            mem_full,
    input  wire logic [vrss_pkg::EFFECT_SLOTS-1:0] effect_recorded,
    input  wire logic [vrss_pkg::EFFECT_SLOTS-1:0] effect_erased,
    input  wire logic                            record_active_bit,
    input  wire logic                            play_active,
    input  wire logic                            erase_active,
    input  wire logic                            standalone_start,
    input  wire logic                            layout_ok,
    output logic                                 cmd_accept,
    output logic [7:0]                           cmd_code,
    output logic                                 led_out
);
    import vrss_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VRSS_IDLE  = 2'b00,
        VRSS_FLASH = 2'b01
    } vrss_flash_t;

    logic [PSW_WIDTH-1:0]    primary_status_word;
    logic [SSB_WIDTH-1:0]    secondary_status_byte;
    logic [PSW_WIDTH-1:0]    psw_snap_reg;
    logic [SSB_WIDTH-1:0]    ssb_snap_reg;
    logic                    done_reg;
    logic                    end_of_message_flag;
    logic                    cmd_err_reg;
    logic [EFFECT_SLOTS-1:0] effect_reg;
    logic [EFFECT_SLOTS-1:0] effect_bits;
    logic                    ready_bit;
    logic                    ss_sync;
    logic                    ss_prev_reg;
    logic                    frame_end;
    logic                    clear_flags_command;
    // link domain
    logic [7:0]              shift_reg;
    logic [4:0]              pos_reg;
    logic                    wrapped_reg;
    logic [7:0]              link_cmd_reg;
    logic [3:0]              link_bytes_reg;
    logic [3:0]              bytes_cnt_reg;
    logic                    miso_bit;
    // command screen
    logic [7:0]              op;
    logic                    is_priority;
    logic                    is_addr_cmd;
    logic                    busy;
    logic                    allowed_busy;
    logic                    short_addr;
    logic                    reject;
    // indicator
    vrss_flash_t             flash_state_reg;
    logic [31:0]             flash_cnt_reg;
    logic [3:0]              flash_edges_reg;

    // ------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------
    // five flags low, row split across both bytes
    always_comb begin
        primary_status_word = '0;
        primary_status_word[PSW_ERR_BIT]  = cmd_err_reg;            // see [R12]
        primary_status_word[PSW_FULL_BIT] = mem_full;               // see [R11]
        primary_status_word[PSW_PWR_BIT]  = powered_in & spi_mode;  // see [R10]
        primary_status_word[PSW_EOM_BIT]  = end_of_message_flag;    // see [R09]
        primary_status_word[PSW_DONE_BIT] = done_reg;               // see [R08]
        primary_status_word[PSW_ROW_LO_POS +: 3] = active_row_address[2:0];          // see [R06] [R07]
        primary_status_word[PSW_ROW_HI_POS +: 8] = active_row_address[ROW_WIDTH-1:3]; // see [R05] [R06]
    end

    // effect order: slot four high by default, slot one high if selected
    always_comb begin
        for (int i = 0; i < EFFECT_SLOTS; i++) begin
            effect_bits[i] = EFFECT_ONE_HI ? effect_reg[EFFECT_SLOTS-1-i] : effect_reg[i]; // see [R19]
        end
    end

    assign busy      = record_active_bit | play_active | erase_active;
    assign ready_bit = ~busy;

    // secondary byte fields
    always_comb begin
        secondary_status_byte = '0;
        secondary_status_byte[SSB_EFFECT_POS +: EFFECT_SLOTS] = effect_bits; // see [R15]
        secondary_status_byte[SSB_REC_BIT]   = record_active_bit;  // see [R17]
        secondary_status_byte[SSB_PLAY_BIT]  = play_active;        // see [R17]
        secondary_status_byte[SSB_ERASE_BIT] = erase_active;       // see [R17]
        secondary_status_byte[SSB_RDY_BIT]   = ready_bit;          // see [R15]
    end

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    // done and end-of-message: a set beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_reg            <= 1'b0;
            end_of_message_flag <= 1'b0;
        end else begin
            done_reg            <= op_done | (done_reg & ~clear_flags_command);               // see [R08]
            end_of_message_flag <= eom_detect | (end_of_message_flag & ~clear_flags_command); // see [R09]
        end
    end

    // effect slots: record sets, erase clears, record wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            effect_reg <= '0;
        end else begin
            effect_reg <= effect_recorded | (effect_reg & ~effect_erased); // see [R16]
        end
    end

    // ------------------------------------------------------------
    // frame crossing
    // ------------------------------------------------------------
    vrss_sync #(
        .RESET_VAL (1'b1)
    ) u_ss_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (ss_n),
        .dout    (ss_sync)
    );

    // frame end seen in core domain; link words are still then
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ss_prev_reg <= 1'b1;
        end else begin
            ss_prev_reg <= ss_sync;
        end
    end
    assign frame_end = ss_sync & ~ss_prev_reg;

    // snapshot follows live status between frames, frozen inside one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            psw_snap_reg <= '0;
            ssb_snap_reg <= '0;
        end else if (ss_sync) begin
            psw_snap_reg <= primary_status_word;   // see [R13]
            ssb_snap_reg <= secondary_status_byte; // see [R14]
        end
    end

    // ------------------------------------------------------------
    // link domain: shift in on rising sclk, frame held in reset by ss_n
    // ------------------------------------------------------------
    always_ff @(posedge sclk or posedge ss_n) begin
        if (ss_n) begin
            shift_reg     <= '0;
            pos_reg       <= '0;
            wrapped_reg   <= 1'b0;
            bytes_cnt_reg <= '0;
        end else begin
            shift_reg <= {mosi, shift_reg[7:1]};  // lsb first
            if (pos_reg == 5'h1f) begin
                pos_reg     <= LINK_POS_WRAP;
                wrapped_reg <= 1'b1;
            end else begin
                pos_reg <= pos_reg + 5'h01;
            end
            if (pos_reg[2:0] == 3'h7 && bytes_cnt_reg != LINK_BYTES_MAX) begin
                bytes_cnt_reg <= bytes_cnt_reg + 4'h1;
            end
        end
    end

    // command and byte count outlive the frame for the core to take
    always_ff @(posedge sclk) begin
        if (pos_reg == 5'h07 && !wrapped_reg) begin
            link_cmd_reg <= {mosi, shift_reg[7:1]};
        end
        if (pos_reg == 5'h00 && !wrapped_reg) begin
            link_bytes_reg <= 4'h0;
        end else if (pos_reg[2:0] == 3'h7 && bytes_cnt_reg != LINK_BYTES_MAX) begin
            link_bytes_reg <= bytes_cnt_reg + 4'h1;
        end
    end

    // response bit: primary word, then secondary byte for status read
    always_comb begin
        if (pos_reg < 5'h10) begin
            miso_bit = psw_snap_reg[pos_reg[3:0]];              // see [R13]
        end else if (pos_reg < 5'h18 && !wrapped_reg &&
                     (link_cmd_reg & CMD_LED_MASK) == CMD_STATUS) begin
            miso_bit = ssb_snap_reg[pos_reg[2:0]];              // see [R14]
        end else begin
            miso_bit = psw_snap_reg[{pos_reg[3], pos_reg[2:0]}];
        end
    end
    assign miso_out = miso_bit & ~ss_n;
    assign miso_oe  = ~ss_n;

    // ------------------------------------------------------------
    // command screen
    // ------------------------------------------------------------
    assign op          = link_cmd_reg & CMD_LED_MASK;
    assign is_priority = (op == CMD_POWER_UP) || (op == CMD_STOP) || (op == CMD_RESET) ||
                         (op == CMD_CLEAR) || (op == CMD_STATUS) || (op == CMD_POWER_DN) ||
                         (op == CMD_DEVID);
    assign is_addr_cmd = (op == CMD_SET_PLAY) || (op == CMD_SET_REC) || (op == CMD_SET_ERASE);
    assign short_addr  = is_addr_cmd && (link_bytes_reg < 4'(1 + ADDR_BYTES)); // see [R12]
    assign allowed_busy = (op == CMD_RESET) || (op == CMD_CLEAR) || (op == CMD_STATUS) ||
                          (op == CMD_POWER_DN) ||
                          ((op == CMD_STOP) && (record_active_bit || play_active));
    assign reject      = short_addr || (busy && !allowed_busy);               // see [R18]
    assign clear_flags_command = cmd_accept && (cmd_code == CMD_CLEAR);

    // take the finished frame: accept or flag an error
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_err_reg <= 1'b0;
            cmd_accept  <= 1'b0;
            cmd_code    <= '0;
        end else begin
            cmd_accept <= 1'b0;
            if (frame_end && link_bytes_reg != 4'h0) begin
                cmd_err_reg <= reject;      // see [R12] [R18]
                cmd_accept  <= ~reject;
                cmd_code    <= op;
            end
        end
    end

    // ------------------------------------------------------------
    // layout fault indicator
    // ------------------------------------------------------------
    // seven on-off flashes when push-button use starts on a bad layout
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flash_state_reg <= VRSS_IDLE;
            flash_cnt_reg   <= '0;
            flash_edges_reg <= '0;
            led_out         <= 1'b0;
        end else begin
            case (flash_state_reg)
                VRSS_IDLE: begin
                    led_out <= 1'b0;
                    if (standalone_start && !layout_ok) begin  // see [R04]
                        flash_state_reg <= VRSS_FLASH;
                        flash_cnt_reg   <= '0;
                        flash_edges_reg <= '0;
                        led_out         <= 1'b1;
                    end
                end
                VRSS_FLASH: begin
                    if (flash_cnt_reg == 32'(FLASH_HALF - 1)) begin
                        flash_cnt_reg   <= '0;
                        flash_edges_reg <= flash_edges_reg + 4'h1;
                        if (flash_edges_reg == 4'(2 * FAULT_FLASHES - 1)) begin
                            flash_state_reg <= VRSS_IDLE;  // see [R04]
                            led_out         <= 1'b0;
                        end else begin
                            led_out <= ~led_out;
                        end
                    end else begin
                        flash_cnt_reg <= flash_cnt_reg + 32'h1;
                    end
                end
                default: begin
                    flash_state_reg <= VRSS_IDLE;
                    led_out         <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [3:0] rise_cnt_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || flash_state_reg == VRSS_IDLE) begin
            rise_cnt_reg <= '0;
        end else if (led_out && !$past(led_out)) begin
            rise_cnt_reg <= rise_cnt_reg + 4'h1;
        end
    end

    sequence s_fault_start;
        standalone_start && !layout_ok && flash_state_reg == VRSS_IDLE;
    endsequence

    sequence s_flash_on;
        flash_state_reg == VRSS_FLASH && led_out;
    endsequence

    property p_fault_flash;
        @(posedge clk) disable iff (sys_rst)
        s_fault_start |=> s_flash_on;
    endproperty
    a_fault_flash: assert property (p_fault_flash) else $error("fault did not start flashing"); // see [R04]

    property p_flash_count;
        @(posedge clk) disable iff (sys_rst)
        $fell(flash_state_reg == VRSS_FLASH) |-> rise_cnt_reg == 4'(FAULT_FLASHES);
    endproperty
    a_flash_count: assert property (p_flash_count) else $error("wrong number of flashes"); // see [R04]

    property p_done_sticky;
        @(posedge clk) disable iff (sys_rst)
        op_done ##1 (!clear_flags_command)[*3] |-> primary_status_word[PSW_DONE_BIT];
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost"); // see [R08]

    property p_eom_clear;
        @(posedge clk) disable iff (sys_rst)
        clear_flags_command && !eom_detect |=> !end_of_message_flag;
    endproperty
    a_eom_clear: assert property (p_eom_clear) else $error("eom flag not cleared"); // see [R09]

    property p_eom_set;
        @(posedge clk) disable iff (sys_rst)
        eom_detect |=> end_of_message_flag;
    endproperty
    a_eom_set: assert property (p_eom_set) else $error("eom flag not set"); // see [R09]

    property p_snap_row;
        @(posedge clk) disable iff (sys_rst)
        ss_sync |=> psw_snap_reg[15:8] == $past(active_row_address[10:3]) &&
                    psw_snap_reg[7:5] == $past(active_row_address[2:0]);
    endproperty
    a_snap_row: assert property (p_snap_row) else $error("row field misplaced"); // see [R06]

    property p_reject;
        @(posedge clk) disable iff (sys_rst)
        frame_end && link_bytes_reg != 4'h0 && busy && !allowed_busy |=> cmd_err_reg && !cmd_accept;
    endproperty
    a_reject: assert property (p_reject) else $error("busy command not rejected"); // see [R18]

    property p_short_addr;
        @(posedge clk) disable iff (sys_rst)
        frame_end && is_addr_cmd && link_bytes_reg != 4'h0 && link_bytes_reg < 4'h6
            |=> cmd_err_reg && !cmd_accept;
    endproperty
    a_short_addr: assert property (p_short_addr) else $error("short address command executed"); // see [R12]

    property p_ready;
        @(posedge clk) disable iff (sys_rst)
        ss_sync && busy |=> !ssb_snap_reg[SSB_RDY_BIT];
    endproperty
    a_ready: assert property (p_ready) else $error("ready high while busy"); // see [R15]

endmodule

// ===== verification/vrss_host.sv
/*
 * Host model: serial master that frames commands and captures replies.
 * Assumes sclk idles high and the device samples on rising sclk.
 */
`timescale 1ns/1ps
module vrss_host (
    output logic      sclk,
    output logic      ss_n,
    output logic      mosi,
    input  wire logic miso_out,
    input  wire logic miso_oe
);
    realtime half = 7.5;

    // idle levels of the host lines
    initial begin
        sclk = 1'b1;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    // one frame, lsb first; reply bit taken just before each rise
    task automatic frame(input logic [47:0] tx, input int nb, output logic [47:0] rx);
        rx = '0;
        ss_n = 1'b0;
        #20;
        for (int k = 0; k < nb * 8; k++) begin
            sclk = 1'b0;
            mosi = tx[k];
            #(half);
            rx[k] = miso_oe ? miso_out : 1'bx;
            sclk = 1'b1;
            #(half);
        end
        mosi = 1'b0;
        #5;
        ss_n = 1'b1;
    endtask
endmodule

// ===== verification/vrss_status_regs_test.sv
/*
 * Self-checking bench of the status block with a host model.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/1ps
module vrss_status_regs_test;
    import vrss_pkg::*;
    logic clk = 0, sys_rst = 1, op_done = 0, eom_detect = 0, powered_in = 1, spi_mode = 1;
    logic mem_full = 0, record_active_bit = 0, play_active = 0, erase_active = 0;
    logic standalone_start = 0, layout_ok = 1, sclk, ss_n, mosi, miso_out, miso_oe, cmd_accept, led_out;
    logic [3:0] effect_recorded = 0, effect_erased = 0;
    logic [10:0] row = 11'h5a3;
    logic [7:0] cmd_code;
    logic [47:0] rx;
    logic acc;
    int n_mismatch = 0, compares = 0, cycles = 0;

    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    initial begin
        forever #2 clk = ~clk;
    end
    vrss_status_regs #(.FLASH_HALF(4)) i_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .ss_n(ss_n),
        .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe), .active_row_address(row), .op_done(op_done),
        .eom_detect(eom_detect), .powered_in(powered_in), .spi_mode(spi_mode), .mem_full(mem_full),
        .effect_recorded(effect_recorded), .effect_erased(effect_erased),
        .record_active_bit(record_active_bit), .play_active(play_active), .erase_active(erase_active),
        .standalone_start(standalone_start), .layout_ok(layout_ok), .cmd_accept(cmd_accept),
        .cmd_code(cmd_code), .led_out(led_out));
    vrss_host i_host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // frame, then watch for the accept pulse; also spaces frames
    task automatic xfer(input logic [7:0] op, input int nb);
        i_host.frame({40'h0, op}, nb, rx);
        acc = 1'b0;
        repeat (12) begin
            tick(1);
            if (cmd_accept === 1'b1) acc = 1'b1;
        end
    endtask
    function automatic logic [15:0] psw(input logic [4:0] f);
        return {row[10:3], row[2:0], f};
    endfunction
    task automatic give_verdict();
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_status();
        mem_full = 1'b1;
        op_done = 1'b1;
        eom_detect = 1'b1;
        effect_recorded = 4'b0101;
        tick(1);
        op_done = 1'b0;
        eom_detect = 1'b0;
        effect_recorded = 4'b0000;
        tick(3);
        xfer(CMD_STATUS, 4);
        chk("status word", rx[15:0], psw(5'b11110));
        chk("secondary", rx[23:16], 8'h51);
        chk("repeat high", rx[31:24], row[10:3]);
    endtask
    task automatic t_clear();
        xfer(CMD_CLEAR | 8'h10, 1);
        chk("clear accepted", {acc, cmd_code}, {1'b1, CMD_CLEAR});
        xfer(CMD_DEVID, 2);
        chk("flags cleared", rx[15:0], psw(5'b00110));
    endtask
    task automatic t_badaddr();
        xfer(CMD_SET_PLAY, 3);
        chk("short address", acc, 1'b0);
        mem_full = 1'b0;
        spi_mode = 1'b0;
        xfer(CMD_STATUS, 2);
        chk("error set", rx[15:0], psw(5'b00001));
        spi_mode = 1'b1;
        xfer(CMD_STATUS, 2);
        chk("error gone", rx[15:0], psw(5'b00100));
    endtask
    task automatic t_busy();
        record_active_bit = 1'b1;
        effect_erased = 4'b0001;
        tick(1);
        effect_erased = 4'b0000;
        tick(3);
        xfer(CMD_DEVID, 1);
        chk("busy reject", acc, 1'b0);
        xfer(CMD_STATUS, 3);
        chk("busy error", rx[15:0], psw(5'b00101));
        chk("rec busy", rx[23:16], 8'h48);
        xfer(CMD_STOP, 1);
        chk("stop taken", acc, 1'b1);
        record_active_bit = 1'b0;
        play_active = 1'b1;
        erase_active = 1'b1;
        tick(3);
        xfer(CMD_STATUS, 3);
        chk("play erase", rx[23:16], 8'h46);
        play_active = 1'b0;
        erase_active = 1'b0;
    endtask
    // count lit phases of the indicator after a start
    task automatic t_led(input logic ok, input int exp);
        int lit;
        logic prev;
        lit = 0;
        prev = 1'b0;
        layout_ok = ok;
        standalone_start = 1'b1;
        tick(1);
        standalone_start = 1'b0;
        chk("led start", led_out, !ok);
        repeat (80) begin
            if (led_out === 1'b1 && !prev) lit++;
            prev = led_out;
            tick(1);
        end
        chk("lit phases", 16'(lit), 16'(exp));
    endtask

    // ----------------------------------------
    // main sequence and hang guard
    // ----------------------------------------
    initial begin
        tick(2);
        sys_rst = 1'b0;
        tick(6);
        t_status();
        t_clear();
        t_badaddr();
        t_busy();
        xfer(CMD_RESET, 1);
        t_led(1'b0, FAULT_FLASHES);
        t_led(1'b1, 0);
        give_verdict();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
endmodule
